// ### verilog/scr_pkg.sv
// Constants and types for the synthesizer config/status register segment.
// Assumes byte-wide registers reached over a 32-bit Avalon-MM slave port.
package scr_pkg;
  // Bus shape: printed offsets are register indexes, byte address = 4*index
  localparam int AW = 10;
  localparam int DW = 32;
  localparam int IW = 8;

  // Register indexes
  localparam logic [IW-1:0] IDX_RSV_A      = 8'h42;
  localparam logic [IW-1:0] IDX_RSV_B      = 8'h43;
  localparam logic [IW-1:0] IDX_CAL_RISE   = 8'h44;
  localparam logic [IW-1:0] IDX_CAL_FALL   = 8'h45;
  localparam logic [IW-1:0] IDX_RSV_C      = 8'h4b;
  localparam logic [IW-1:0] IDX_RSV_D      = 8'h4c;
  localparam logic [IW-1:0] IDX_OVERRIDE   = 8'h4d;
  localparam logic [IW-1:0] IDX_TBL_SCALE  = 8'h4f;
  localparam logic [IW-1:0] IDX_SYNC_MON   = 8'h53;
  localparam logic [IW-1:0] IDX_CONV_START = 8'h54;
  localparam logic [IW-1:0] IDX_FCNT_LOW   = 8'h55;
  localparam logic [IW-1:0] IDX_FCNT_MID   = 8'h56;
  localparam logic [IW-1:0] IDX_FCNT_HIGH  = 8'h57;
  localparam logic [IW-1:0] IDX_STATUS     = 8'h58;

  // Plain read/write bytes, stored in one array
  localparam int NUM_RW = 9;
  localparam int SLOT_CAL_RISE  = 2;
  localparam int SLOT_CAL_FALL  = 3;
  localparam int SLOT_OVERRIDE  = 6;
  localparam int SLOT_TBL_SCALE = 7;
  localparam int SLOT_SYNC_MON  = 8;
  localparam logic [IW-1:0] RW_IDX [NUM_RW] = '{
    IDX_RSV_A, IDX_RSV_B, IDX_CAL_RISE, IDX_CAL_FALL, IDX_RSV_C,
    IDX_RSV_D, IDX_OVERRIDE, IDX_TBL_SCALE, IDX_SYNC_MON};

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Field positions
  localparam int OVR_CORE_BIT    = 0;
  localparam int OVR_BAND_BIT    = 1;
  localparam int OVR_BIAS_BIT    = 2;
  localparam int STAB_EXT_BIT    = 7;
  localparam int CAL_V_MSB       = 6;
  localparam int MON_CLEAR_BIT   = 1;
  localparam int SYNC_SEL_BIT    = 5;
  localparam int MON_PD_BIT      = 6;
  localparam int CONV_START_BIT  = 0;
  localparam int ST_TABLE_BUSY   = 7;
  localparam int ST_SYNC_OK      = 6;
  localparam int ST_DEL_STROBE   = 5;
  localparam int ST_DEL_DIR      = 4;
  localparam int ST_CONV_BUSY    = 2;

  // Oscillator selection widths
  localparam int BAND_W = 9;
  localparam int BIAS_W = 6;

  // Avalon response codes
  localparam logic [1:0] RESP_OK     = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef struct packed {
    logic [BAND_W-1:0] band;
    logic              core;
    logic [BIAS_W-1:0] bias;
  } scr_osc_sel_t;

  typedef struct packed {
    logic table_busy;
    logic delay_strobe;
    logic delay_dir;
    logic sync_pass;
  } scr_status_in_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } scr_bus_state_t;
endpackage

// ### verilog/scr_regs.sv
// Config/status register segment of the synthesizer: override muxes for
// oscillator core/band/bias, table scale, sync monitor control, converter
// start/busy and the read-only counter and status bytes.
// Assumes an Avalon-MM master on ref_clk and all inputs synchronous to it.
//
// Notes on behaviour
// - Band override selects manual band value
// - Core override bit 0 selects manual core
// - Bias override bit 2 selects manual bias
// - Table scale byte is eight times frequency ratio
// - Monitor power-down bit 6 stops monitor
// - Sync select bit 5: 0 CML/PECL, 1 LVDS
// - Monitor clear bit 1 holds latch cleared
// - Status bit 6 reports sync window met
// - Start bit 0 begins conversion, rest read-only
// - 24-bit counter over three bytes, LSB lowest
// - Status bit 7 shows table generation busy
// - Status bits 5/4 show delay strobe, direction
// - Direction flag: 0 negative, 1 positive
// - Busy flag high while conversion runs
// - Calibration byte bit 7 extends driver stability
// - Two 7-bit calibration voltage components, read/write
// - Every stored register resets to zero; counter low byte reads the live count
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
module scr_regs (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic [scr_pkg::AW-1:0]      address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [scr_pkg::DW-1:0]      writedata,
  input  wire logic [3:0]                  byteenable,
  output logic      [scr_pkg::DW-1:0]      readdata,
  output logic      [1:0]                  response,
  output logic                             waitrequest,
  input  wire scr_pkg::scr_osc_sel_t       cal_sel,
  input  wire scr_pkg::scr_osc_sel_t       manual_sel,
  output scr_pkg::scr_osc_sel_t            osc_sel,
  output logic      [7:0]                  table_scaling_factor,
  output logic                             align_monitor_powerdown,
  output logic                             sync_source_lvds,
  output logic                             align_monitor_clear,
  output logic                             tune_driver_stability_ext,
  output logic      [scr_pkg::CAL_V_MSB:0] cal_voltage_rise,
  output logic      [scr_pkg::CAL_V_MSB:0] cal_voltage_fall,
  output logic                             conversion_start,
  input  wire logic                        conversion_done,
  input  wire scr_pkg::scr_status_in_t     status_in,
  input  wire logic [23:0]                 freq_count_result
);

  scr_pkg::scr_bus_state_t state;
  logic [scr_pkg::IW-1:0]  idx;
  logic [7:0]              rw_byte [scr_pkg::NUM_RW];
  logic [scr_pkg::NUM_RW-1:0] rw_hit;
  logic                    start_bit;
  logic                    conv_busy;
  logic [7:0]              status;
  logic [15:0]             fcnt_snap;
  logic                    wr_take;
  logic                    rd_take;
  logic                    mapped;
  logic [7:0]              next_rdbyte;

  assign idx = address[scr_pkg::AW-1:2];
  // One wait state: the answer phase follows every request phase
  assign waitrequest = (read | write) && (state != scr_pkg::BUS_ANSWER);
  assign wr_take = write && (state == scr_pkg::BUS_ANSWER) && byteenable[0];
  assign rd_take = read && (state == scr_pkg::BUS_IDLE);

  // Bus phase
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= scr_pkg::BUS_IDLE;
    end else begin
      case (state)
        scr_pkg::BUS_IDLE: begin
          if (read | write) begin
            state <= scr_pkg::BUS_ANSWER;
          end
        end
        scr_pkg::BUS_ANSWER: state <= scr_pkg::BUS_IDLE;
        default: state <= scr_pkg::BUS_IDLE;
      endcase
    end
  end

  // Plain read/write bytes, reserved ones included
  genvar g;
  generate
    for (g = 0; g < scr_pkg::NUM_RW; g++) begin : g_rw
      assign rw_hit[g] = (idx == scr_pkg::RW_IDX[g]);
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          rw_byte[g] <= scr_pkg::RESET_BYTE;
        end else if (wr_take && rw_hit[g]) begin
          rw_byte[g] <= writedata[7:0];
        end
      end
    end
  endgenerate

  // Read mux; unmapped indexes read zero with a decode error
  always_comb begin
    next_rdbyte = 8'h00;
    mapped = 1'b1;
    case (idx)
      scr_pkg::IDX_CONV_START: next_rdbyte = {7'h00, start_bit};
      scr_pkg::IDX_FCNT_LOW:   next_rdbyte = freq_count_result[7:0];
      scr_pkg::IDX_FCNT_MID:   next_rdbyte = fcnt_snap[7:0];
      scr_pkg::IDX_FCNT_HIGH:  next_rdbyte = fcnt_snap[15:8];
      scr_pkg::IDX_STATUS:     next_rdbyte = status;
      default: begin
        mapped = |rw_hit;
        for (int i = 0; i < scr_pkg::NUM_RW; i++) begin
          if (rw_hit[i]) begin
            next_rdbyte = rw_byte[i];
          end
        end
      end
    endcase
  end

  // Read data and response are loaded in the request phase so they stand
  // at the edge where waitrequest is low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      readdata <= '0;
      response <= scr_pkg::RESP_OK;
    end else if ((read | write) && state == scr_pkg::BUS_IDLE) begin
      readdata <= read ? {24'h000000, next_rdbyte} : '0;
      response <= mapped ? scr_pkg::RESP_OK : scr_pkg::RESP_DECERR;
    end
  end

  // Reading the low byte freezes the upper two at the edge that loads the
  // low byte, so a low-mid-high read returns one coherent count
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fcnt_snap <= 16'h0000;
    end else if (rd_take && idx == scr_pkg::IDX_FCNT_LOW) begin
      fcnt_snap <= freq_count_result[23:8];
    end
  end

  // Conversion start: each written one gives exactly one pulse
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      start_bit        <= 1'b0;
      conversion_start <= 1'b0;
    end else begin
      conversion_start <= 1'b0;
      if (wr_take && idx == scr_pkg::IDX_CONV_START) begin
        start_bit <= writedata[scr_pkg::CONV_START_BIT];
        conversion_start <= writedata[scr_pkg::CONV_START_BIT];
      end
    end
  end

  // Busy: a start in the same cycle as done wins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      conv_busy <= 1'b0;
    end else if (conversion_start) begin
      conv_busy <= 1'b1;
    end else if (conversion_done) begin
      conv_busy <= 1'b0;
    end
  end

  // Status byte; pass flag held clear while monitor is cleared or off
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status <= scr_pkg::RESET_BYTE;
    end else begin
      status <= 8'h00;
      status[scr_pkg::ST_TABLE_BUSY] <= status_in.table_busy;
      status[scr_pkg::ST_SYNC_OK] <= status_in.sync_pass &&
        !align_monitor_clear && !align_monitor_powerdown;
      status[scr_pkg::ST_DEL_STROBE] <= status_in.delay_strobe;
      status[scr_pkg::ST_DEL_DIR] <= status_in.delay_dir;
      status[scr_pkg::ST_CONV_BUSY] <= conv_busy;
    end
  end

  // Oscillator selection, registered to keep the outputs glitch free
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      osc_sel <= '0;
    end else begin
      osc_sel.band <= rw_byte[scr_pkg::SLOT_OVERRIDE][scr_pkg::OVR_BAND_BIT]
        ? manual_sel.band : cal_sel.band;
      osc_sel.core <= rw_byte[scr_pkg::SLOT_OVERRIDE][scr_pkg::OVR_CORE_BIT]
        ? manual_sel.core : cal_sel.core;
      osc_sel.bias <= rw_byte[scr_pkg::SLOT_OVERRIDE][scr_pkg::OVR_BIAS_BIT]
        ? manual_sel.bias : cal_sel.bias;
    end
  end

  assign table_scaling_factor = rw_byte[scr_pkg::SLOT_TBL_SCALE];
  assign align_monitor_powerdown =
    rw_byte[scr_pkg::SLOT_SYNC_MON][scr_pkg::MON_PD_BIT];
  assign sync_source_lvds =
    rw_byte[scr_pkg::SLOT_SYNC_MON][scr_pkg::SYNC_SEL_BIT];
  assign align_monitor_clear =
    rw_byte[scr_pkg::SLOT_SYNC_MON][scr_pkg::MON_CLEAR_BIT];
  assign tune_driver_stability_ext =
    rw_byte[scr_pkg::SLOT_CAL_RISE][scr_pkg::STAB_EXT_BIT];
  assign cal_voltage_rise =
    rw_byte[scr_pkg::SLOT_CAL_RISE][scr_pkg::CAL_V_MSB:0];
  assign cal_voltage_fall =
    rw_byte[scr_pkg::SLOT_CAL_FALL][scr_pkg::CAL_V_MSB:0];

endmodule

// ### test/scr_regs_checker.sv
// Checker for scr_regs: wait state, start pulse, override muxes, controls.
// Assumes the selection inputs stay zero while reset is held.
`timescale 1ns/1ps
module scr_regs_checker (
  input wire logic                   ref_clk,
  input wire logic                   rst_n,
  input wire logic [scr_pkg::AW-1:0] address,
  input wire logic                   read,
  input wire logic                   write,
  input wire logic [scr_pkg::DW-1:0] writedata,
  input wire logic [3:0]             byteenable,
  input wire logic [scr_pkg::DW-1:0] readdata,
  input wire logic [1:0]             response,
  input wire logic                   waitrequest,
  input wire scr_pkg::scr_osc_sel_t  cal_sel,
  input wire scr_pkg::scr_osc_sel_t  manual_sel,
  input wire scr_pkg::scr_osc_sel_t  osc_sel,
  input wire logic [7:0]             table_scaling_factor,
  input wire logic                   align_monitor_powerdown,
  input wire logic                   sync_source_lvds,
  input wire logic                   align_monitor_clear,
  input wire logic                   conversion_start
);
  logic [2:0] ovr;
  wire  [7:0] idx   = address[9:2];
  wire        wr_ok = write & ~waitrequest & byteenable[0];
  // Shadow of the override bits, so the mux can be checked from the bus
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ovr <= 3'h0;
    end else if (wr_ok && idx == 8'h4d) begin
      ovr <= writedata[2:0];
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_start_write;
    wr_ok && idx == 8'h54 && writedata[0];
  endsequence
  a_wait_once: assert property (
    (read | write) && waitrequest |=> !waitrequest) else $error("long wait");
  a_start_pulse: assert property (
    s_start_write |=> conversion_start ##1 !conversion_start)
    else $error("start pulse wrong");
  a_start_cause: assert property (
    $rose(conversion_start) |-> $past(wr_ok && idx == 8'h54 && writedata[0]))
    else $error("start without write");
  a_core_mux: assert property (
    osc_sel.core == $past(ovr[0] ? manual_sel.core : cal_sel.core))
    else $error("core select wrong");
  a_band_mux: assert property (
    osc_sel.band == $past(ovr[1] ? manual_sel.band : cal_sel.band))
    else $error("band select wrong");
  a_bias_mux: assert property (
    osc_sel.bias == $past(ovr[2] ? manual_sel.bias : cal_sel.bias))
    else $error("bias select wrong");
  a_scale_write: assert property (
    $changed(table_scaling_factor) |-> $past(wr_ok && idx == 8'h4f)
    && table_scaling_factor == $past(writedata[7:0])) else $error("scale");
  a_monitor_write: assert property (
    $changed({align_monitor_powerdown, sync_source_lvds, align_monitor_clear})
    |-> $past(wr_ok && idx == 8'h53) && {align_monitor_powerdown,
    sync_source_lvds, align_monitor_clear} == $past({writedata[6:5],
    writedata[1]})) else $error("monitor control");
  a_decode_err: assert property (
    read && !waitrequest && idx == 8'h50 |-> response == 2'b11)
    else $error("no decode error");
endmodule
bind scr_regs scr_regs_checker u_chk (.ref_clk, .rst_n, .address, .read,
  .write, .writedata, .byteenable, .readdata, .response, .waitrequest,
  .cal_sel, .manual_sel, .osc_sel, .table_scaling_factor,
  .align_monitor_powerdown, .sync_source_lvds, .align_monitor_clear,
  .conversion_start);

// ### test/scr_regs_bench.sv
// Bench for scr_regs: Avalon byte accesses against expected values.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
module scr_regs_bench;
  logic                    ref_clk, rst_n, read, write, conversion_done;
  logic                    waitrequest, conversion_start, align_monitor_clear;
  logic                    align_monitor_powerdown, sync_source_lvds;
  logic                    tune_driver_stability_ext;
  logic [9:0]              address;
  logic [31:0]             writedata, readdata;
  logic [3:0]              byteenable;
  logic [1:0]              response, rsp;
  logic [7:0]              table_scaling_factor, q;
  logic [6:0]              cal_voltage_rise, cal_voltage_fall;
  logic [23:0]             freq_count_result;
  scr_pkg::scr_osc_sel_t   cal_sel, manual_sel, osc_sel;
  scr_pkg::scr_status_in_t status_in;
  int                      num_errors, tests_run, starts, s0;
  scr_regs dut (.ref_clk, .rst_n, .address, .read, .write, .writedata,
    .byteenable, .readdata, .response, .waitrequest, .cal_sel, .manual_sel,
    .osc_sel, .table_scaling_factor, .align_monitor_powerdown,
    .sync_source_lvds, .align_monitor_clear, .tune_driver_stability_ext,
    .cal_voltage_rise, .cal_voltage_fall, .conversion_start,
    .conversion_done, .status_in, .freq_count_result);
  initial begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (!rst_n) starts <= 0;
    else if (conversion_start === 1'b1) starts <= starts + 1;
  end
  task automatic chk(input string n, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Request held until a rising edge that samples waitrequest low; data
  // and response are taken at that edge, then the request is released
  task automatic acc(input logic w, input logic [7:0] i, d);
    int n;
    n = 0;
    @(posedge ref_clk);
    read <= !w;
    write <= w;
    address <= {i, 2'b00};
    writedata <= {24'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      chk("waitrequest", 16'h0, 16'h1);
      finish_test();
    end
    q = readdata[7:0];
    rsp = response;
    read <= 0;
    write <= 0;
  endtask
  task automatic wr(input logic [7:0] i, d);
    acc(1, i, d);
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] i, e);
    acc(0, i, 8'h00);
    chk("readback", e, q);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    finish_test();
  end
  initial begin
    {rst_n, read, write, conversion_done, address, writedata} = '0;
    {cal_sel, manual_sel, status_in, freq_count_result} = '0;
    byteenable = 4'hf;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1;
    cal_sel <= '{9'h1aa, 1'b0, 6'h15};
    manual_sel <= '{9'h055, 1'b1, 6'h2a};
    for (int i = 0; i < 9; i++) rd(scr_pkg::RW_IDX[i], 8'h00);
    for (int i = 8'h54; i < 8'h59; i++) rd(8'(i), 8'h00);
    $display("end reset");
    for (int i = 0; i < 9; i++) wr(scr_pkg::RW_IDX[i], 8'(8'h81 + 17 * i));
    for (int i = 0; i < 9; i++)
      rd(scr_pkg::RW_IDX[i], 8'(8'h81 + 17 * i));
    chk("stab", 1, tune_driver_stability_ext);
    chk("rise", 7'h23, cal_voltage_rise);
    chk("fall", 7'h34, cal_voltage_fall);
    for (int v = 0; v < 3; v++) begin
      wr(8'h4f, 8'(v));
      chk("scale", v, table_scaling_factor);
    end
    for (int c = 0; c < 8; c++) begin
      wr(8'h4d, 8'(c));
      @(negedge ref_clk);
      chk("core", c[0], osc_sel.core);
      chk("band", c[1] ? 9'h055 : 9'h1aa, osc_sel.band);
      chk("bias", c[2] ? 6'h2a : 6'h15, osc_sel.bias);
    end
    $display("end registers");
    @(posedge ref_clk);
    status_in <= 4'hf;
    wr(8'h53, 8'h00);
    rd(8'h58, 8'hf0);
    wr(8'h53, 8'h02);
    chk("clear", 1, align_monitor_clear);
    rd(8'h58, 8'hb0);
    wr(8'h53, 8'h40);
    chk("powerdown", 1, align_monitor_powerdown);
    rd(8'h58, 8'hb0);
    wr(8'h53, 8'h20);
    chk("lvds", 1, sync_source_lvds);
    rd(8'h58, 8'hf0);
    @(posedge ref_clk);
    status_in <= 4'h2;
    $display("end monitor");
    s0 = starts;
    wr(8'h54, 8'h01);
    @(negedge ref_clk);
    chk("starts", s0 + 1, starts);
    acc(0, 8'h54, 8'h00);
    chk("start byte", 8'h01, q);
    rd(8'h58, 8'h14);
    @(posedge ref_clk);
    conversion_done <= 1;
    @(posedge ref_clk);
    conversion_done <= 0;
    rd(8'h58, 8'h10);
    wr(8'h54, 8'h01);
    repeat (10) @(negedge ref_clk);
    wr(8'h54, 8'hfe);
    chk("starts", s0 + 2, starts);
    rd(8'h54, 8'h00);
    $display("end converter");
    @(posedge ref_clk);
    freq_count_result <= 24'h123456;
    rd(8'h55, 8'h56);
    @(posedge ref_clk);
    freq_count_result <= 24'hfedcba;
    rd(8'h56, 8'h34);
    rd(8'h57, 8'h12);
    wr(8'h58, 8'hff);
    chk("ro resp", 2'b00, rsp);
    rd(8'h58, 8'h14);
    acc(0, 8'h50, 8'h00);
    chk("bad resp", 2'b11, rsp);
    chk("bad data", 8'h00, q);
    $display("end bus");
    finish_test();
  end
endmodule
